/* core/cdn_cmd_port.sv */
`timescale 1ns/100ps
// Summary of operation
// - entry direction bit steps address counter down or up after data access
// - shift-on-write bit shifts whole display on each text write
// - display enable off hides characters, text memory kept
// - cursor visible bit shows underline cursor on bottom dot row
// - blink bit toggles cursor about every half second
// - cursor shift moves address counter left or right by one
// - display shift moves view, address counter and memory unchanged
// - cursor wraps past 40th place to line two; lines shift together
// - last address command selects glyph or text memory for data; clear selects text memory
// - busy flag set during operations; new instructions refused until clear
// - busy read also returns the shared address counter
// - data write steps counter; only a text write applies entry-mode display shift
// - data read steps counter and never shifts display
// - clear fills text with blanks, zeroes counter, sets increment
// - strobe low means other port inputs are ignored, except on the first clock after it falls, which takes the nibble
// - return home zeroes counter and undoes display shift
module cdn_cmd_port
    import cdn_pkg::*;
#(
    parameter int CLEAR_CYCLES = CLEAR_CYC,
    parameter int BLINK_CYCLES = BLINK_CYC
)(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // nibble port
    input  wire cdn_pins_t   pins,
    output logic [3:0]       nibble_out,
    output logic             nibble_oe,
    // display view
    output cdn_view_t        view
);

    // =====================================================================
    // state
    cdn_state_t       state_ff, nxt_state;
    logic [CNT_W-1:0] busy_cnt_ff, nxt_busy_cnt;
    logic [6:0]       clr_idx_ff, nxt_clr_idx;
    logic [6:0]       ac_ff, nxt_ac;
    logic [5:0]       offset_ff, nxt_offset;
    logic             glyph_sel_ff, nxt_glyph_sel;
    logic             step_up_ff, nxt_step_up;
    logic             shift_wr_ff, nxt_shift_wr;
    logic             disp_on_ff, nxt_disp_on;
    logic             cur_vis_ff, nxt_cur_vis;
    logic             blink_ff, nxt_blink;
    logic             four_bit_ff, nxt_four_bit;
    logic             phase_ff, nxt_phase;
    logic [3:0]       upper_ff, nxt_upper;
    logic             strobe_ff;
    logic [CNT_W-1:0] blink_cnt_ff, nxt_blink_cnt;
    logic             blink_ph_ff, nxt_blink_ph;
    logic [3:0]       nib_out_ff, nxt_nib_out;
    logic             nib_oe_ff, nxt_nib_oe;
    cdn_view_t        view_ff, nxt_view;

    logic [7:0]       text_ram  [128];
    logic [7:0]       glyph_ram [64];

    logic             strobe_fall, byte_done, busy, exec_go;
    logic [7:0]       byte_in, rd_byte, mem_rd;
    logic             is_cmd, is_wdata, is_rdata, is_status;
    logic             wr_text, wr_glyph;

    function automatic logic [6:0] step_ac(input logic [6:0] a, input logic up,
                                           input logic glyph);
        logic [6:0] r;
        r = up ? a + 7'd1 : a - 7'd1;
        if (glyph)
            r = {1'b0, r[5:0]};
        else if (up && a == LINE1_LAST)
            r = LINE2_FIRST;
        else if (up && a == LINE2_LAST)
            r = LINE1_FIRST;
        else if (!up && a == LINE1_FIRST)
            r = LINE2_LAST;
        else if (!up && a == LINE2_FIRST)
            r = LINE1_LAST;
        return r;
    endfunction

    function automatic logic [5:0] step_off(input logic [5:0] o, input logic up);
        logic [5:0] r;
        if (up)
            r = (o == SHIFT_MAX) ? 6'd0 : o + 6'd1;
        else
            r = (o == 6'd0) ? SHIFT_MAX : o - 6'd1;
        return r;
    endfunction

    // =====================================================================
    // decode
    assign busy        = (state_ff != ST_IDLE);
    assign strobe_fall = strobe_ff && !pins.transfer_strobe;
    assign byte_done   = strobe_fall && four_bit_ff && phase_ff;
    assign byte_in     = {upper_ff, pins.nibble_bus};
    assign is_status   = !pins.cmd_data_select && pins.read_write_select;
    assign is_cmd      = !pins.cmd_data_select && !pins.read_write_select;
    assign is_wdata    = pins.cmd_data_select && !pins.read_write_select;
    assign is_rdata    = pins.cmd_data_select && pins.read_write_select;
    assign exec_go     = byte_done && !busy && !is_status;
    assign mem_rd      = glyph_sel_ff ? glyph_ram[ac_ff[5:0]] : text_ram[ac_ff];
    assign rd_byte     = pins.cmd_data_select ? mem_rd : {busy, ac_ff};
    assign wr_text     = exec_go && is_wdata && !glyph_sel_ff;
    assign wr_glyph    = exec_go && is_wdata && glyph_sel_ff;

    // =====================================================================
    // next state
    always_comb
    begin
        nxt_state     = state_ff;
        nxt_busy_cnt  = busy_cnt_ff;
        nxt_clr_idx   = clr_idx_ff;
        nxt_ac        = ac_ff;
        nxt_offset    = offset_ff;
        nxt_glyph_sel = glyph_sel_ff;
        nxt_step_up   = step_up_ff;
        nxt_shift_wr  = shift_wr_ff;
        nxt_disp_on   = disp_on_ff;
        nxt_cur_vis   = cur_vis_ff;
        nxt_blink     = blink_ff;
        nxt_four_bit  = four_bit_ff;
        nxt_phase     = phase_ff;
        nxt_upper     = upper_ff;
        unique case (state_ff)
            ST_IDLE:
            begin
                nxt_busy_cnt = '0;
            end
            ST_EXEC, ST_CLEAR:
            begin
                nxt_busy_cnt = busy_cnt_ff - 1'b1;
                if (clr_idx_ff != 7'h7f)
                    nxt_clr_idx = clr_idx_ff + 7'd1;
                if (busy_cnt_ff == CNT_W'(1))
                    nxt_state = ST_IDLE;
            end
        endcase
        if (strobe_fall && !four_bit_ff && is_cmd
            && pins.nibble_bus[3:1] == INIT_NIB_HI)
            nxt_four_bit = (pins.nibble_bus == INIT_NIB_4B);
        if (strobe_fall && four_bit_ff)
        begin
            nxt_phase = !phase_ff;
            nxt_upper = pins.nibble_bus;
        end
        if (exec_go)
        begin
            nxt_state    = ST_EXEC;
            nxt_busy_cnt = CNT_W'(EXEC_CYC);
            if (is_cmd)
            begin
                if (byte_in[CMD_TEXT_ADDR])
                begin
                    nxt_ac        = byte_in[6:0];
                    nxt_glyph_sel = 1'b0;
                end
                else if (byte_in[CMD_GLYPH_ADDR])
                begin
                    nxt_ac        = {1'b0, byte_in[5:0]};
                    nxt_glyph_sel = 1'b1;
                end
                else if (byte_in[CMD_FUNC_SET])
                    nxt_four_bit = 1'b1;
                else if (byte_in[CMD_SHIFT])
                begin
                    if (byte_in[SH_TARGET])
                        nxt_offset = step_off(offset_ff, byte_in[SH_DIR]);
                    else
                        nxt_ac = step_ac(ac_ff, byte_in[SH_DIR], glyph_sel_ff);
                end
                else if (byte_in[CMD_DISP_CTRL])
                begin
                    nxt_disp_on = byte_in[DC_DISPLAY];
                    nxt_cur_vis = byte_in[DC_CURSOR];
                    nxt_blink   = byte_in[DC_BLINK];
                end
                else if (byte_in[CMD_ENTRY])
                begin
                    nxt_step_up  = byte_in[EM_STEP_UP];
                    nxt_shift_wr = byte_in[EM_SHIFT_WR];
                end
                else if (byte_in[CMD_HOME])
                begin
                    nxt_ac     = LINE1_FIRST;
                    nxt_offset = 6'd0;
                end
                else if (byte_in[CMD_CLEAR])
                begin
                    nxt_state     = ST_CLEAR;
                    nxt_busy_cnt  = CNT_W'(CLEAR_CYCLES);
                    nxt_clr_idx   = 7'd0;
                    nxt_ac        = LINE1_FIRST;
                    nxt_offset    = 6'd0;
                    nxt_step_up   = 1'b1;
                    nxt_glyph_sel = 1'b0;
                end
            end
            else
            begin
                nxt_ac = step_ac(ac_ff, step_up_ff, glyph_sel_ff);
                // shift on text write, never on read
                if (wr_text && shift_wr_ff)
                    nxt_offset = step_off(offset_ff, step_up_ff);
            end
        end
    end

    // =====================================================================
    // pins, blink and view
    always_comb
    begin
        nxt_nib_oe    = pins.transfer_strobe && pins.read_write_select && four_bit_ff;
        nxt_nib_out   = nib_out_ff;
        if (pins.transfer_strobe && !strobe_ff)
            nxt_nib_out = phase_ff ? rd_byte[3:0] : rd_byte[7:4];
        nxt_blink_cnt = blink_cnt_ff + 1'b1;
        nxt_blink_ph  = blink_ph_ff;
        if (blink_cnt_ff >= CNT_W'(BLINK_CYCLES - 1))
        begin
            nxt_blink_cnt = '0;
            nxt_blink_ph  = !blink_ph_ff;
        end
        nxt_view.display_enable = disp_on_ff;
        nxt_view.cursor_shown   = disp_on_ff && cur_vis_ff && (!blink_ff || blink_ph_ff);
        nxt_view.glyph_select   = glyph_sel_ff;
        nxt_view.shift_offset   = offset_ff;
        nxt_view.addr_counter   = ac_ff;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff     <= ST_IDLE;
            busy_cnt_ff  <= '0;
            clr_idx_ff   <= 7'h7f;
            ac_ff        <= '0;
            offset_ff    <= '0;
            glyph_sel_ff <= 1'b0;
            step_up_ff   <= 1'b1;
            shift_wr_ff  <= 1'b0;
            disp_on_ff   <= 1'b0;
            cur_vis_ff   <= 1'b0;
            blink_ff     <= 1'b0;
            four_bit_ff  <= 1'b0;
            phase_ff     <= 1'b0;
            upper_ff     <= '0;
            strobe_ff    <= 1'b0;
            blink_cnt_ff <= '0;
            blink_ph_ff  <= 1'b0;
            nib_out_ff   <= '0;
            nib_oe_ff    <= 1'b0;
            view_ff      <= '0;
        end
        else
        begin
            state_ff     <= nxt_state;
            busy_cnt_ff  <= nxt_busy_cnt;
            clr_idx_ff   <= nxt_clr_idx;
            ac_ff        <= nxt_ac;
            offset_ff    <= nxt_offset;
            glyph_sel_ff <= nxt_glyph_sel;
            step_up_ff   <= nxt_step_up;
            shift_wr_ff  <= nxt_shift_wr;
            disp_on_ff   <= nxt_disp_on;
            cur_vis_ff   <= nxt_cur_vis;
            blink_ff     <= nxt_blink;
            four_bit_ff  <= nxt_four_bit;
            phase_ff     <= nxt_phase;
            upper_ff     <= nxt_upper;
            strobe_ff    <= pins.transfer_strobe;
            blink_cnt_ff <= nxt_blink_cnt;
            blink_ph_ff  <= nxt_blink_ph;
            nib_out_ff   <= nxt_nib_out;
            nib_oe_ff    <= nxt_nib_oe;
            view_ff      <= nxt_view;
        end
    end

    // =====================================================================
    // memories; clear fill writes one location per cycle
    always_ff @(posedge hclk)
    begin
        if (state_ff == ST_CLEAR && clr_idx_ff != 7'h7f)
            text_ram[clr_idx_ff] <= BLANK_CODE;
        else if (wr_text)
            text_ram[ac_ff] <= byte_in;
        if (wr_glyph)
            glyph_ram[ac_ff[5:0]] <= byte_in;
    end

    // =====================================================================
    // ahb-lite slave, zero wait states
    logic        dph_wr_ff, nxt_dph_wr;
    logic [7:0]  dph_addr_ff, nxt_dph_addr;
    logic [6:0]  peek_ff, nxt_peek;
    logic [31:0] rdata_ff, nxt_rdata;
    cdn_status_t stat;
    logic        a_phase;

    assign a_phase = hsel && hready && htrans == HTRANS_NONSEQ;
    assign stat    = '{busy, four_bit_ff, glyph_sel_ff, step_up_ff, shift_wr_ff,
                       disp_on_ff, cur_vis_ff, blink_ff, offset_ff, ac_ff};

    always_comb
    begin
        nxt_dph_wr   = a_phase && hwrite;
        nxt_dph_addr = a_phase ? haddr[7:0] : dph_addr_ff;
        nxt_peek     = peek_ff;
        if (dph_wr_ff && dph_addr_ff == REG_PEEK_ADDR)
            nxt_peek = hwdata[6:0];
        nxt_rdata    = rdata_ff;
        if (a_phase && !hwrite)
        begin
            unique case (haddr[7:0])
                REG_STATUS:    nxt_rdata = 32'(stat);
                REG_PEEK_ADDR: nxt_rdata = 32'(peek_ff);
                REG_PEEK_DATA: nxt_rdata = 32'(text_ram[peek_ff]);
                default:       nxt_rdata = WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dph_wr_ff   <= 1'b0;
            dph_addr_ff <= '0;
            peek_ff     <= '0;
            rdata_ff    <= WORD_ZERO;
        end
        else
        begin
            dph_wr_ff   <= nxt_dph_wr;
            dph_addr_ff <= nxt_dph_addr;
            peek_ff     <= nxt_peek;
            rdata_ff    <= nxt_rdata;
        end
    end

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = rdata_ff;
    assign nibble_out = nib_out_ff;
    assign nibble_oe  = nib_oe_ff;
    assign view       = view_ff;

    // =====================================================================
    // checks
    localparam int A_EXEC = EXEC_CYC;

    sequence s_text_write;
        exec_go && is_wdata && !glyph_sel_ff;
    endsequence

    sequence s_busy_hold;
        busy [*8];
    endsequence

    a_busy_after_op: assert property (@(posedge hclk) disable iff (!hresetn)
        (exec_go && !is_cmd) |=> s_busy_hold)
        else $error("busy flag not held after operation");

    a_busy_ends: assert property (@(posedge hclk) disable iff (!hresetn)
        (exec_go && is_wdata) |-> ##[A_EXEC:A_EXEC] busy ##1 !busy)
        else $error("busy period length wrong");

    a_step_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_text_write and (step_up_ff && ac_ff == LINE1_LAST)) |=> ac_ff == LINE2_FIRST)
        else $error("counter did not wrap to line two");

    a_write_step: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_text_write and (step_up_ff && ac_ff < LINE1_LAST)) |=> ac_ff == $past(ac_ff) + 7'd1)
        else $error("counter not stepped after write");

    a_read_noshift: assert property (@(posedge hclk) disable iff (!hresetn)
        (exec_go && is_rdata) |=> $stable(offset_ff) && ac_ff != $past(ac_ff))
        else $error("read shifted display or kept counter");

    a_dshift_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
        (exec_go && is_cmd && byte_in[7:3] == 5'b00011) |=> $stable(ac_ff)
            && offset_ff != $past(offset_ff))
        else $error("display shift touched counter");

    a_clear_home: assert property (@(posedge hclk) disable iff (!hresetn)
        (exec_go && is_cmd && byte_in == 8'h01) |=> ac_ff == LINE1_FIRST && step_up_ff
            && state_ff == ST_CLEAR)
        else $error("clear did not home and set increment");

    a_strobe_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
        !strobe_ff |=> $stable(phase_ff) && $stable(upper_ff) && $stable(four_bit_ff))
        else $error("inputs taken while strobe low");

    a_home_unshift: assert property (@(posedge hclk) disable iff (!hresetn)
        (exec_go && is_cmd && byte_in[7:1] == 7'h01) |=> offset_ff == 6'd0)
        else $error("home left display shifted");

endmodule // cdn_cmd_port

/* pkg/cdn_pkg.sv */
package cdn_pkg;

    // =====================================================================
    // timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int EXEC_TIME_NS    = 40_000;
    localparam int CLEAR_TIME_NS   = 1_640_000;
    localparam int BLINK_HALF_NS   = 500_000_000;
    localparam int EXEC_CYC        = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_CYC       = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLINK_CYC       = BLINK_HALF_NS / CLK_PERIOD_NS;
    localparam int CNT_W           = 24;

    // =====================================================================
    // text memory map
    localparam logic [6:0] LINE1_FIRST = 7'h00;
    localparam logic [6:0] LINE1_LAST  = 7'h27;
    localparam logic [6:0] LINE2_FIRST = 7'h40;
    localparam logic [6:0] LINE2_LAST  = 7'h67;
    localparam logic [5:0] SHIFT_MAX   = 6'h27;
    localparam logic [7:0] BLANK_CODE  = 8'h20;
    localparam logic [3:0] INIT_NIB_4B = 4'h2;
    localparam logic [2:0] INIT_NIB_HI = 3'h1;

    // =====================================================================
    // instruction decode bits
    localparam int CMD_TEXT_ADDR  = 7;
    localparam int CMD_GLYPH_ADDR = 6;
    localparam int CMD_FUNC_SET   = 5;
    localparam int CMD_SHIFT      = 4;
    localparam int CMD_DISP_CTRL  = 3;
    localparam int CMD_ENTRY      = 2;
    localparam int CMD_HOME       = 1;
    localparam int CMD_CLEAR      = 0;
    localparam int SH_TARGET      = 3;
    localparam int SH_DIR         = 2;
    localparam int DC_DISPLAY     = 2;
    localparam int DC_CURSOR      = 1;
    localparam int DC_BLINK       = 0;
    localparam int EM_STEP_UP     = 1;
    localparam int EM_SHIFT_WR    = 0;

    // =====================================================================
    // bus registers (byte addresses)
    localparam logic [7:0]  REG_STATUS    = 8'h00;
    localparam logic [7:0]  REG_PEEK_ADDR = 8'h04;
    localparam logic [7:0]  REG_PEEK_DATA = 8'h08;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

    typedef struct packed {
        logic       transfer_strobe;
        logic       cmd_data_select;
        logic       read_write_select;
        logic [3:0] nibble_bus;
    } cdn_pins_t;

    typedef struct packed {
        logic       display_enable;
        logic       cursor_shown;
        logic       glyph_select;
        logic [5:0] shift_offset;
        logic [6:0] addr_counter;
    } cdn_view_t;

    typedef struct packed {
        logic       internal_op_pending;
        logic       four_bit_mode;
        logic       glyph_select;
        logic       addr_step_direction;
        logic       shift_on_write;
        logic       display_enable;
        logic       cursor_visible;
        logic       cursor_blink;
        logic [5:0] shift_offset;
        logic [6:0] addr_counter;
    } cdn_status_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_EXEC  = 3'b010,
        ST_CLEAR = 3'b100
    } cdn_state_t;

endpackage

/* test/cdn_host_mdl.sv */
`timescale 1ns/100ps
module cdn_host_mdl
    import cdn_pkg::*;
#(
    parameter int INIT_CYC = 300
)(
    // clock
    input  wire logic       hclk,
    // nibble port
    output cdn_pins_t       pins,
    input  wire logic [3:0] nibble_out
);
    initial pins = '0;

    task automatic nib(input logic rs, input logic rw, input logic [3:0] n,
                       output logic [3:0] q);
        @(posedge hclk);
        pins <= '{1'b0, rs, rw, n};
        @(posedge hclk);
        pins.transfer_strobe <= 1'b1;
        repeat (3) @(posedge hclk);
        q = nibble_out;
        pins.transfer_strobe <= 1'b0;
        @(posedge hclk);
        pins <= '{1'b0, rs, 1'b0, ~n};
        repeat (10) @(posedge hclk);
    endtask

    task automatic put(input logic rs, input logic [7:0] b, input int gap);
        logic [3:0] q;
        nib(rs, 1'b0, b[7:4], q);
        nib(rs, 1'b0, b[3:0], q);
        repeat (gap) @(posedge hclk);
    endtask

    task automatic get(input logic rs, output logic [7:0] b);
        nib(rs, 1'b1, 4'h0, b[7:4]);
        nib(rs, 1'b1, 4'h0, b[3:0]);
    endtask

    task automatic init;
        logic [3:0] q;
        for (int i = 0; i < 4; i++)
        begin
            repeat (INIT_CYC) @(posedge hclk);
            nib(1'b0, 1'b0, (i < 3) ? 4'h3 : 4'h2, q);
        end
        repeat (INIT_CYC) @(posedge hclk);
    endtask

    task automatic noise;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge hclk);
            pins <= '{1'b0, i[0], 1'b0, i[3:0]};
        end
    endtask
endmodule // cdn_host_mdl

/* test/char_display_nibble_cmd_port_tb_top.sv */
`timescale 1ns/100ps
module char_display_nibble_cmd_port_tb_top;
    import cdn_pkg::*;
    localparam int GAP = 450;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    cdn_pins_t   pins;
    logic [3:0]  nib_q;
    logic        nib_oe;
    logic        oe_seen;
    cdn_view_t   view;
    logic [7:0]  b;
    int          bad_count;
    int          check_count;
    // =====================================
    // design and host
    cdn_cmd_port #(.CLEAR_CYCLES(200), .BLINK_CYCLES(16)) cdn_cmd_port_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(),
        .pins(pins), .nibble_out(nib_q), .nibble_oe(nib_oe), .view(view));
    cdn_host_mdl cdn_host_mdl_inst (.hclk(hclk), .pins(pins), .nibble_out(nib_q));
    // remembers whether the device ever drove the nibble lines
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            oe_seen <= 1'b0;
        else if (nib_oe)
            oe_seen <= 1'b1;
    end
    // =====================================
    // helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= 32'(a);
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= 32'(d);
        do @(posedge hclk); while (hready !== 1'b1);
        b = hrdata[7:0];
    endtask
    task automatic peek(input logic [7:0] a);
        ahb(1'b1, REG_PEEK_ADDR, a);
        ahb(1'b0, REG_PEEK_DATA, 8'h00);
    endtask
    task automatic p(input logic rs, input logic [7:0] v, input int g = GAP);
        cdn_host_mdl_inst.put(rs, v, g);
    endtask
    // =====================================
    // scenarios
    task automatic t_init;
        cdn_host_mdl_inst.init();
        p(1'b0, 8'h28);
        p(1'b0, 8'h06);
        p(1'b0, 8'h0C);
        p(1'b0, 8'h01, 250);
        chk(8'(view.display_enable), 8'h01);
        chk(8'(view.addr_counter), 8'h00);
        peek(8'h65);
        chk(b, BLANK_CODE);
        ahb(1'b0, REG_STATUS, 8'h00);
        chk(b, 8'h00);
        chk(8'(oe_seen), 8'h00);
        $display("init done");
    endtask
    task automatic t_write;
        p(1'b0, 8'hA6);
        p(1'b1, 8'h41, 0);
        cdn_host_mdl_inst.get(1'b0, b);
        chk(b, 8'hA7);
        chk(8'(oe_seen), 8'h01);
        chk(8'(nib_oe), 8'h00);
        p(1'b0, 8'h90);
        chk(8'(view.addr_counter), 8'h27);
        p(1'b0, 8'h14);
        chk(8'(view.addr_counter), 8'h40);
        peek(8'h26);
        chk(b, 8'h41);
        $display("write done");
    endtask
    task automatic t_entry;
        p(1'b0, 8'h04);
        p(1'b0, 8'h85);
        p(1'b1, 8'h42);
        chk(8'(view.addr_counter), 8'h04);
        p(1'b0, 8'h07);
        p(1'b1, 8'h43);
        chk(8'(view.addr_counter), 8'h05);
        chk(8'(view.shift_offset), 8'h01);
        cdn_host_mdl_inst.get(1'b1, b);
        chk(b, 8'h42);
        repeat (GAP) @(posedge hclk);
        chk(8'(view.addr_counter), 8'h06);
        chk(8'(view.shift_offset), 8'h01);
        $display("entry done");
    endtask
    task automatic t_shift;
        p(1'b0, 8'h10);
        chk(8'(view.addr_counter), 8'h05);
        p(1'b0, 8'h1C);
        p(1'b0, 8'h18);
        chk(8'(view.addr_counter), 8'h05);
        chk(8'(view.shift_offset), 8'h01);
        p(1'b0, 8'h02);
        chk(8'(view.addr_counter), 8'h00);
        chk(8'(view.shift_offset), 8'h00);
        $display("shift done");
    endtask
    task automatic t_disp;
        p(1'b0, 8'h0A);
        chk(8'(view.cursor_shown), 8'h00);
        chk(8'(view.display_enable), 8'h00);
        peek(8'h04);
        chk(b, 8'h43);
        p(1'b0, 8'h0E);
        chk(8'(view.cursor_shown), 8'h01);
        p(1'b0, 8'h0F);
        @(negedge hclk);
        b = 8'(view.cursor_shown);
        repeat (16) @(negedge hclk);
        chk(8'(view.cursor_shown), ~b & 8'h01);
        $display("display done");
    endtask
    task automatic t_glyph;
        p(1'b0, 8'h40);
        chk(8'(view.glyph_select), 8'h01);
        p(1'b1, 8'h1F);
        cdn_host_mdl_inst.noise();
        chk(8'(view.addr_counter), 8'h01);
        p(1'b0, 8'h80);
        chk(8'(view.glyph_select), 8'h00);
        peek(8'h00);
        chk(b, BLANK_CODE);
        $display("glyph done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // =====================================
    // clock, run, watchdog
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_init();
        t_write();
        t_entry();
        t_shift();
        t_disp();
        t_glyph();
        give_verdict();
    end
    initial
    begin
        repeat (40000) @(posedge hclk);
        bad_count++;
        give_verdict();
    end
endmodule // char_display_nibble_cmd_port_tb_top
